// File: spi_regs_pkg.sv
// Functional notes
// - status bit 5 sets when a frame starts with the transmit queue empty
// - reading the status register clears that error bit
// - status bit 4 shows receive queue full
// - status bit 3 shows receive queue holds at least one entry
// - status bit 2 shows transmit queue empty
// - status bit 1 shows transmit queue has room
// - status bit 0 shows a serial transfer under way or a transmit queue that is not empty
// - five interrupt enables at bits 4..0; zero masks the cause
// - masked state shows causes at enable positions, disabled ones read zero
// - raw state shows all five causes regardless of enables
// - masked state: receive full at 4, transmit empty at 0
// - reading 0x038 clears transmit overrun; bit 0 returns its state
// - reading 0x03C clears receive overrun
// - reading 0x040 clears receive underrun
// - writes to the clear registers have no effect
// - reading 0x048 clears all three overrun and underrun causes
// - transmit DMA requests only while DMA control bit 1 was set one cycle earlier
// - receive DMA requests only while DMA control bit 0 was set one cycle earlier
// - any word-aligned write in window 0x060..0x0EC pushes one transmit entry unless the queue is full
// - any word-aligned read in the window pops the oldest receive entry, bits 15:0
// - transmit empty cause when transmit count is at or below its level
// - receive full cause when receive count exceeds its level
package spi_regs_pkg;

    localparam int ADDR_W    = 8;
    localparam int BUS_W     = 32;
    localparam int DATA_W    = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W     = 3;
    localparam int LVL_W     = 2;

    localparam logic [ADDR_W-1:0] OFF_TX_IRQ_LEVEL = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_RX_IRQ_LEVEL = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS       = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK     = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_MASKED       = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_RAW          = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_TXO_CLEAR    = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_RXO_CLEAR    = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_RXU_CLEAR    = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_ALL_CLEAR    = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_DMA_ENABLE   = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_DMA_TX_LEVEL = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_DMA_RX_LEVEL = 8'h54;
    localparam logic [ADDR_W-1:0] OFF_DATA_FIRST   = 8'h60;
    localparam logic [ADDR_W-1:0] OFF_DATA_LAST    = 8'hEC;

    localparam int DMA_TX_BIT = 1;
    localparam int DMA_RX_BIT = 0;

    localparam logic [4:0] IRQ_MASK_RST = 5'h1F;
    localparam logic [1:0] DMA_EN_RST   = 2'h0;
    localparam logic [LVL_W-1:0] LVL_RST = 2'h0;

    // bit 4 down to bit 0, matching enable, masked and raw layouts
    typedef struct packed {
        logic rx_full;
        logic rx_overrun;
        logic rx_underrun;
        logic tx_overrun;
        logic tx_empty;
    } irq_bits_t;

    // bit 5 down to bit 0 of the status register
    typedef struct packed {
        logic tx_start_empty_error;
        logic rx_fifo_full_flag;
        logic rx_fifo_nonempty_flag;
        logic tx_fifo_empty_flag;
        logic tx_fifo_room_flag;
        logic busy;
    } status_bits_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             full;
        logic             empty;
    } fifo_stat_t;

endpackage

// File: spi_word_fifo.sv
`timescale 1ns/1ps
module spi_word_fifo
    import spi_regs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output spi_regs_pkg::fifo_stat_t stat
);
    import spi_regs_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] rptr;
    logic [CNT_W-1:0] count;

    wire full    = (count == CNT_W'(DEPTH));
    wire empty   = (count == '0);
    wire do_push = push & ~full;
    wire do_pop  = pop & ~empty;

    assign head = mem[rptr];
    assign stat = '{count: count, full: full, empty: empty};

    // storage holds no reset; only pointers define contents
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wptr] <= push_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wptr <= PTR_W'(wptr + 1'b1);
            end
            if (do_pop) begin
                rptr <= PTR_W'(rptr + 1'b1);
            end
            count <= CNT_W'(count + CNT_W'(do_push) - CNT_W'(do_pop));
        end
    end

endmodule

// File: spi_frame_shift.sv
`timescale 1ns/1ps
module spi_frame_shift #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             sclk_pin,
    input  wire logic             ss_n_pin,
    input  wire logic             mosi_pin,
    input  wire logic [WIDTH-1:0] tx_word,
    output logic                  frame_start,
    output logic      [WIDTH-1:0] rx_word,
    output logic                  rx_done,
    output logic                  active,
    output logic                  miso,
    output logic                  miso_oe_n
);
    localparam int BC_W = $clog2(WIDTH);
    localparam logic [BC_W-1:0] LAST_BIT = BC_W'(WIDTH - 1);

    logic [2:0]       sclk_sync;
    logic [2:0]       ss_sync;
    logic [1:0]       mosi_sync;
    logic [BC_W-1:0]  bit_cnt;
    logic [WIDTH-1:0] tx_shift;
    logic [WIDTH-1:0] rx_shift;
    logic             load;
    logic             cont;

    wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    wire ss_fall   = ~ss_sync[1] & ss_sync[2];
    wire selected  = ~ss_sync[1];
    wire last_rise = selected & sclk_rise & (bit_cnt == LAST_BIT);
    // preload at frame end pops nothing: select may rise before the next word
    wire cont_rise = selected & sclk_rise & (bit_cnt == '0) & cont;
    wire [WIDTH-1:0] rx_next = {rx_shift[WIDTH-2:0], mosi_sync[1]};

    // mode 0: sample on rise, shift on fall, none at frame boundary
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync   <= '0;
            ss_sync     <= 3'h7;
            mosi_sync   <= '0;
            bit_cnt     <= '0;
            tx_shift    <= '0;
            rx_shift    <= '0;
            rx_word     <= '0;
            rx_done     <= 1'b0;
            frame_start <= 1'b0;
            load        <= 1'b0;
            cont        <= 1'b0;
            active      <= 1'b0;
            miso        <= 1'b0;
            miso_oe_n   <= 1'b1;
        end else begin
            sclk_sync   <= {sclk_sync[1:0], sclk_pin};
            ss_sync     <= {ss_sync[1:0], ss_n_pin};
            mosi_sync   <= {mosi_sync[0], mosi_pin};
            frame_start <= ss_fall | cont_rise;
            load        <= ss_fall | last_rise;
            rx_done     <= last_rise;
            active      <= selected;
            miso_oe_n   <= ~selected;
            if (!selected) begin
                bit_cnt <= '0;
                cont    <= 1'b0;
            end else if (sclk_rise) begin
                if (bit_cnt == LAST_BIT) begin
                    cont <= 1'b1;
                end
                rx_shift <= rx_next;
                bit_cnt  <= (bit_cnt == LAST_BIT) ? '0 : BC_W'(bit_cnt + 1'b1);
            end
            if (last_rise) begin
                rx_word <= rx_next;
            end
            if (load) begin
                tx_shift <= tx_word;
                miso     <= tx_word[WIDTH-1];
            end else if (selected && sclk_fall && bit_cnt != '0) begin
                tx_shift <= {tx_shift[WIDTH-2:0], 1'b0};
                miso     <= tx_shift[WIDTH-2];
            end
        end
    end

endmodule

// File: spi_status_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module spi_status_regs
    import spi_regs_pkg::*;
#(
    parameter int WIDTH = spi_regs_pkg::DATA_W,
    parameter int DEPTH = spi_regs_pkg::FIFO_DEPTH
) (
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    input  wire logic [spi_regs_pkg::ADDR_W-1:0] bus_addr,
    input  wire logic [spi_regs_pkg::BUS_W-1:0]  bus_wdata,
    input  wire logic                            bus_wr,
    input  wire logic                            bus_rd,
    output logic      [spi_regs_pkg::BUS_W-1:0]  bus_rdata,
    input  wire logic                            link_sclk,
    input  wire logic                            link_ss_n,
    input  wire logic                            link_mosi,
    output logic                                 link_miso,
    output logic                                 link_miso_oe_n,
    output logic                                 tx_dma_req,
    output logic                                 rx_dma_req,
    output logic                                 irq
);
    import spi_regs_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    function automatic logic [BUS_W-1:0] widen(input logic [WIDTH-1:0] val);
        widen = BUS_W'(val);
    endfunction

    function automatic logic [CNT_W-1:0] lvl(input logic [LVL_W-1:0] val);
        lvl = CNT_W'(val);
    endfunction

    // ************************************************************
    // software-visible state
    // ************************************************************

    irq_bits_t         irq_mask;
    irq_bits_t         raw;
    logic [1:0]        dma_enable;
    logic [LVL_W-1:0]  tx_dma_level_field;
    logic [LVL_W-1:0]  rx_dma_level_field;
    logic [LVL_W-1:0]  tx_irq_level;
    logic [LVL_W-1:0]  rx_irq_level;
    logic              tx_start_empty_error;

    irq_bits_t         next_raw;
    logic              next_tx_err;
    logic [BUS_W-1:0]  next_rdata;

    // ************************************************************
    // queues and serial engine
    // ************************************************************

    fifo_stat_t        tx_stat;
    fifo_stat_t        rx_stat;
    logic [WIDTH-1:0]  tx_head;
    logic [WIDTH-1:0]  rx_head;
    logic              frame_start;
    logic [WIDTH-1:0]  rx_word;
    logic              rx_done;
    logic              link_active;

    wire               in_window;
    wire               win_wr;
    wire               win_rd;
    wire               tx_push;
    wire               tx_pop;
    wire               rx_pop;
    wire [WIDTH-1:0]   shift_word;

    // ************************************************************
    // address decode
    // ************************************************************

    wire wr_mask      = bus_wr & hit(bus_addr, OFF_IRQ_MASK);
    wire wr_dma_en    = bus_wr & hit(bus_addr, OFF_DMA_ENABLE);
    wire wr_dma_tx    = bus_wr & hit(bus_addr, OFF_DMA_TX_LEVEL);
    wire wr_dma_rx    = bus_wr & hit(bus_addr, OFF_DMA_RX_LEVEL);
    wire wr_tx_lvl    = bus_wr & hit(bus_addr, OFF_TX_IRQ_LEVEL);
    wire wr_rx_lvl    = bus_wr & hit(bus_addr, OFF_RX_IRQ_LEVEL);
    wire rd_status    = bus_rd & hit(bus_addr, OFF_STATUS);
    wire rd_txo_clear = bus_rd & hit(bus_addr, OFF_TXO_CLEAR);
    wire rd_rxo_clear = bus_rd & hit(bus_addr, OFF_RXO_CLEAR);
    wire rd_rxu_clear = bus_rd & hit(bus_addr, OFF_RXU_CLEAR);
    wire rd_all_clear = bus_rd & hit(bus_addr, OFF_ALL_CLEAR);

    // word-aligned addresses only; byte offsets inside a word miss
    assign in_window = (bus_addr >= OFF_DATA_FIRST) &&
                       (bus_addr <= OFF_DATA_LAST) &&
                       (bus_addr[1:0] == 2'h0);
    assign win_wr    = bus_wr & in_window;
    assign win_rd    = bus_rd & in_window;

    assign tx_push   = win_wr;
    assign rx_pop    = win_rd & ~rx_stat.empty;
    assign tx_pop    = frame_start & ~tx_stat.empty;
    // an empty queue at frame start sends zeros rather than stale data
    assign shift_word = tx_stat.empty ? '0 : tx_head;

    // ************************************************************
    // queue instances
    // ************************************************************

    spi_word_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .push      (tx_push),
        .push_data (bus_wdata[WIDTH-1:0]),
        .pop       (tx_pop),
        .head      (tx_head),
        .stat      (tx_stat)
    );

    spi_word_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .push      (rx_done),
        .push_data (rx_word),
        .pop       (rx_pop),
        .head      (rx_head),
        .stat      (rx_stat)
    );

    spi_frame_shift #(
        .WIDTH (WIDTH)
    ) u_shift (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .sclk_pin    (link_sclk),
        .ss_n_pin    (link_ss_n),
        .mosi_pin    (link_mosi),
        .tx_word     (shift_word),
        .frame_start (frame_start),
        .rx_word     (rx_word),
        .rx_done     (rx_done),
        .active      (link_active),
        .miso        (link_miso),
        .miso_oe_n   (link_miso_oe_n)
    );

    // ************************************************************
    // interrupt causes
    // ************************************************************

    wire tx_over_set  = win_wr & tx_stat.full;
    wire rx_over_set  = rx_done & rx_stat.full;
    wire rx_under_set = win_rd & rx_stat.empty;

    wire tx_over_clr  = rd_txo_clear | rd_all_clear;
    wire rx_over_clr  = rd_rxo_clear | rd_all_clear;
    wire rx_under_clr = rd_rxu_clear | rd_all_clear;

    wire tx_empty_cause = (tx_stat.count <= lvl(tx_irq_level));
    wire rx_full_cause  = (rx_stat.count > lvl(rx_irq_level));

    always_comb begin
        next_raw          = raw;
        next_raw.tx_empty = tx_empty_cause;
        next_raw.rx_full  = rx_full_cause;
        next_raw.tx_overrun  = tx_over_set  | (raw.tx_overrun  & ~tx_over_clr);
        next_raw.rx_overrun  = rx_over_set  | (raw.rx_overrun  & ~rx_over_clr);
        next_raw.rx_underrun = rx_under_set | (raw.rx_underrun & ~rx_under_clr);
    end

    wire irq_bits_t masked = raw & irq_mask;

    // ************************************************************
    // status flags
    // ************************************************************

    wire tx_err_set = frame_start & tx_stat.empty;
    assign next_tx_err = tx_err_set | (tx_start_empty_error & ~rd_status);

    status_bits_t status;
    always_comb begin
        status.tx_start_empty_error  = tx_start_empty_error;
        status.rx_fifo_full_flag     = rx_stat.full;
        status.rx_fifo_nonempty_flag = ~rx_stat.empty;
        status.tx_fifo_empty_flag    = tx_stat.empty;
        status.tx_fifo_room_flag     = ~tx_stat.full;
        status.busy                  = link_active | ~tx_stat.empty;
    end

    // ************************************************************
    // read mux
    // ************************************************************

    wire [BUS_W-1:0] rd_status_word = BUS_W'(status);
    wire [BUS_W-1:0] rd_mask_word   = BUS_W'(irq_mask);
    wire [BUS_W-1:0] rd_masked_word = BUS_W'(masked);
    wire [BUS_W-1:0] rd_raw_word    = BUS_W'(raw);
    wire [BUS_W-1:0] rd_txo_word    = BUS_W'(raw.tx_overrun);
    wire [BUS_W-1:0] rd_rxo_word    = BUS_W'(raw.rx_overrun);
    wire [BUS_W-1:0] rd_rxu_word    = BUS_W'(raw.rx_underrun);
    wire [BUS_W-1:0] rd_all_word    = BUS_W'(raw.tx_overrun | raw.rx_overrun |
                                              raw.rx_underrun);
    wire [BUS_W-1:0] rd_data_word   = rx_stat.empty ? '0 : widen(rx_head);

    always_comb begin
        next_rdata = '0;
        if (bus_rd) begin
            case (bus_addr)
                OFF_TX_IRQ_LEVEL: next_rdata = BUS_W'(tx_irq_level);
                OFF_RX_IRQ_LEVEL: next_rdata = BUS_W'(rx_irq_level);
                OFF_STATUS:       next_rdata = rd_status_word;
                OFF_IRQ_MASK:     next_rdata = rd_mask_word;
                OFF_MASKED:       next_rdata = rd_masked_word;
                OFF_RAW:          next_rdata = rd_raw_word;
                OFF_TXO_CLEAR:    next_rdata = rd_txo_word;
                OFF_RXO_CLEAR:    next_rdata = rd_rxo_word;
                OFF_RXU_CLEAR:    next_rdata = rd_rxu_word;
                OFF_ALL_CLEAR:    next_rdata = rd_all_word;
                OFF_DMA_ENABLE:   next_rdata = BUS_W'(dma_enable);
                OFF_DMA_TX_LEVEL: next_rdata = BUS_W'(tx_dma_level_field);
                OFF_DMA_RX_LEVEL: next_rdata = BUS_W'(rx_dma_level_field);
                default:          next_rdata = in_window ? rd_data_word : '0;
            endcase
        end
    end

    // ************************************************************
    // dma requests
    // ************************************************************

    wire next_tx_dma = dma_enable[DMA_TX_BIT] &
                       (tx_stat.count <= lvl(tx_dma_level_field));
    wire next_rx_dma = dma_enable[DMA_RX_BIT] &
                       (rx_stat.count > lvl(rx_dma_level_field));

    // ************************************************************
    // registers
    // ************************************************************

    // clear registers have no write decode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= IRQ_MASK_RST;
            dma_enable <= DMA_EN_RST;
            tx_irq_level <= LVL_RST;
            rx_irq_level <= LVL_RST;
        end else begin
            if (wr_mask) begin
                irq_mask <= bus_wdata[$bits(irq_bits_t)-1:0];
            end
            if (wr_dma_en) begin
                dma_enable <= bus_wdata[1:0];
            end
            if (wr_tx_lvl) begin
                tx_irq_level <= bus_wdata[LVL_W-1:0];
            end
            if (wr_rx_lvl) begin
                rx_irq_level <= bus_wdata[LVL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_dma_level_field <= LVL_RST;
            rx_dma_level_field <= LVL_RST;
        end else begin
            if (wr_dma_tx) begin
                tx_dma_level_field <= bus_wdata[LVL_W-1:0];
            end
            if (wr_dma_rx) begin
                rx_dma_level_field <= bus_wdata[LVL_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw                  <= '0;
            tx_start_empty_error <= 1'b0;
            bus_rdata            <= '0;
        end else begin
            raw                  <= next_raw;
            tx_start_empty_error <= next_tx_err;
            bus_rdata            <= next_rdata;
        end
    end

    // outputs lag state by one cycle to keep them glitch free
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_dma_req <= 1'b0;
            rx_dma_req <= 1'b0;
            irq        <= 1'b0;
        end else begin
            tx_dma_req <= next_tx_dma;
            rx_dma_req <= next_rx_dma;
            irq        <= |masked;
        end
    end

endmodule

// File: spi_status_monitor.sv
`timescale 1ns/1ps
module spi_status_monitor
    import spi_regs_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic                            clk_sys,
    input wire logic                            rst_n,
    input wire logic [spi_regs_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [spi_regs_pkg::BUS_W-1:0]  bus_wdata,
    input wire logic                            bus_wr,
    input wire logic                            bus_rd,
    input wire logic [spi_regs_pkg::BUS_W-1:0]  bus_rdata,
    input wire logic                            link_ss_n,
    input wire logic                            tx_dma_req,
    input wire logic                            rx_dma_req,
    input wire logic                            irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ************
    // shadow copies of enables
    // ************
    logic [1:0] dma_en;
    logic [4:0] mask;
    wire        in_win = bus_addr >= OFF_DATA_FIRST && bus_addr <= OFF_DATA_LAST;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_en <= 2'h0;
            mask   <= 5'h1F;
        end else if (bus_wr && bus_addr == OFF_DMA_ENABLE) begin
            dma_en <= bus_wdata[1:0];
        end else if (bus_wr && bus_addr == OFF_IRQ_MASK) begin
            mask   <= bus_wdata[4:0];
        end
    end
    sequence s_rd(logic [7:0] a);
        bus_rd && bus_addr == a;
    endsequence
    // quiet link means no frame can set the error between the reads
    sequence s_quiet_pair;
        link_ss_n [*6] ##0 s_rd(OFF_STATUS) ##2 s_rd(OFF_STATUS);
    endsequence
    a_idle_rdata: assert property (!bus_rd |=> bus_rdata == '0)
        else $error("read data without a read");
    a_status_rsvd: assert property (s_rd(OFF_STATUS) |=> bus_rdata[31:6] == '0)
        else $error("status upper bits set");
    a_masked_rsvd: assert property (s_rd(OFF_MASKED) |=> bus_rdata[31:5] == '0)
        else $error("masked state upper bits set");
    a_clear_rsvd: assert property (s_rd(OFF_TXO_CLEAR) |=> bus_rdata[31:1] == '0)
        else $error("clear register upper bits set");
    a_window_upper: assert property (bus_rd && in_win |=> bus_rdata[31:16] == '0)
        else $error("data window upper bits set");
    a_tx_dma_gate: assert property (!dma_en[1] && !$past(dma_en[1]) |-> !tx_dma_req)
        else $error("transmit dma request while disabled");
    a_rx_dma_gate: assert property (!dma_en[0] && !$past(dma_en[0]) |-> !rx_dma_req)
        else $error("receive dma request while disabled");
    a_irq_masked: assert property (mask == 5'h0 && $past(mask) == 5'h0 |-> !irq)
        else $error("interrupt with all causes masked");
    a_err_cleared: assert property (s_quiet_pair |=> !bus_rdata[5])
        else $error("error bit survived a status read");
endmodule
bind spi_status_regs spi_status_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) spi_status_monitor_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .link_ss_n(link_ss_n),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));

// File: spi_link_master.sv
`timescale 1ns/1ps
module spi_link_master (
    input  wire logic        miso,
    output logic             sclk,
    output logic             ss_n,
    output logic             mosi,
    output logic [15:0]      got
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        got  = 16'h0000;
    end
    // one mode-0 frame, msb first; clock stands low outside frames
    task automatic frame(input logic [15:0] w);
        ss_n = 1'b0;
        #240;
        for (int i = 15; i >= 0; i--) begin
            mosi = w[i];
            #160 sclk = 1'b1;
            got = {got[14:0], miso};
            #160 sclk = 1'b0;
        end
        #200 ss_n = 1'b1;
        mosi = ~mosi;
        #400;
    endtask
endmodule

// File: tb_spi_status_regs.sv
`timescale 1ns/1ps
module tb_spi_status_regs;
    import spi_regs_pkg::*;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
    logic        clk_sys, rst_n, bus_wr, bus_rd, sclk, ss_n, mosi, miso, oe_n, txq, rxq, irq;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata;
    logic [15:0] got;
    int          bad_count = 0;
    int          check_count = 0;
    row_t rows [27] = '{
        '{0,8'h28,32'h6}, '{0,8'h2C,32'h1F}, '{0,8'h30,32'h1}, '{0,8'h34,32'h1},
        '{0,8'h4C,32'h0}, '{0,8'h50,32'h0}, '{0,8'h54,32'h0}, '{1,8'h50,32'h7},
        '{0,8'h50,32'h3}, '{1,8'h54,32'h2}, '{0,8'h54,32'h2}, '{1,8'h4C,32'h3},
        '{0,8'h4C,32'h3}, '{1,8'h4C,32'h0}, '{1,8'h2C,32'h0}, '{0,8'h30,32'h0},
        '{0,8'h34,32'h1}, '{1,8'h2C,32'h1F}, '{1,8'h0C,32'hFF}, '{0,8'h0C,32'h0},
        '{1,8'h18,32'h2}, '{0,8'h18,32'h2}, '{1,8'h18,32'h0}, '{1,8'h28,32'h3F},
        '{0,8'h28,32'h6}, '{1,8'h30,32'h1F}, '{0,8'h30,32'h1}};
    spi_status_regs spi_status_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .link_sclk(sclk), .link_ss_n(ss_n), .link_mosi(mosi),
        .link_miso(miso), .link_miso_oe_n(oe_n), .tx_dma_req(txq), .rx_dma_req(rxq), .irq(irq));
    // released line floats high through its pull-up
    spi_link_master link_inst (.miso(oe_n ? 1'b1 : miso), .sclk(sclk), .ss_n(ss_n),
        .mosi(mosi), .got(got));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata, e);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        {rst_n, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 27; i++) begin
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            else rc(rows[i].a, rows[i].d);
        end
        chk({31'h0, irq}, 32'h1);
        $display("register table test done");
        rc(8'h64, 32'h0);
        rc(OFF_RAW, 32'h5);
        rc(OFF_RXU_CLEAR, 32'h1);
        rc(OFF_RAW, 32'h1);
        for (int i = 0; i < 5; i++) wr(i == 4 ? OFF_DATA_LAST : 8'h60 + 8'(i * 32), 32'h5A5AA5C0 + i);
        rc(OFF_STATUS, 32'h1);
        wr(OFF_TXO_CLEAR, 32'h0);
        rc(OFF_RAW, 32'h2);
        rc(OFF_TXO_CLEAR, 32'h1);
        rc(OFF_RAW, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h60, 32'h0);
        rc(OFF_ALL_CLEAR, 32'h1);
        rc(OFF_RAW, 32'h0);
        $display("overflow and clear test done");
        #7;
        for (int i = 0; i < 4; i++) begin
            link_inst.frame(16'h3C00 + 16'(i));
            chk({16'h0, got}, 32'hA5C0 + i);
        end
        rc(OFF_STATUS, 32'h1E);
        rc(OFF_RAW, 32'h11);
        wr(OFF_DMA_ENABLE, 32'h3);
        repeat (2) @(posedge clk_sys);
        #1 chk({30'h0, txq, rxq}, 32'h3);
        wr(OFF_DMA_ENABLE, 32'h0);
        #7 link_inst.frame(16'h3C04);
        chk({16'h0, got}, 32'h0);
        rc(OFF_STATUS, 32'h3E);
        rc(OFF_STATUS, 32'h1E);
        rc(OFF_RAW, 32'h19);
        rc(OFF_RXO_CLEAR, 32'h1);
        for (int i = 0; i < 4; i++) rc(8'h60 + 8'(i * 4), 32'h3C00 + i);
        rc(OFF_STATUS, 32'h6);
        $display("link and dma test done");
        rst_n <= 1'b0;
        #1 chk({30'h0, oe_n, irq}, 32'h2);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(OFF_IRQ_MASK, 32'h1F);
        rc(OFF_DMA_TX_LEVEL, 32'h0);
        $display("second reset test done");
        end_sim();
    end
endmodule
